// [apm_cap_cmd.sv]
// Power, acoustic, host-rate and capacity-limit command handling
//
// The Avalon-MM interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`include "apm_cap_map.svh"

module apm_cap_cmd #(
  parameter int          CYCLES_PER_SEC = `SEC_NS / `CLK_NS,
  parameter logic [47:0] NATIVE_MAX     = 48'h0000_1D1C_5970
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        hard_reset_n_in,
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        access_valid_in,
  input  wire logic [47:0] access_lba_in,
  output logic             access_reject_out,
  output logic             electronics_off_out,
  output logic             heads_parked_out,
  output logic      [6:0]  spindle_pct_out,
  output logic             quiet_seek_out
);
  localparam int PW = $clog2(CYCLES_PER_SEC);
  // All checks below run on the reference clock and sleep during reset
  default clocking chk_clk @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  apm_cap_pkg::taskfile_s  tf_reg;
  apm_cap_pkg::pwr_state_e pwr_reg, pwr_next;
  apm_cap_pkg::deepest_e   deep_reg;
  apm_cap_pkg::sec_state_e sec_reg;
  logic        ack_reg, abt_reg, native_rd_reg, rev_dis_reg, offset_reg;
  logic        y1_set_reg, aam_en_reg, nv_done_reg, hpa_ext_reg;
  logic [8:0]  y1_reg;
  logic [12:0] y2_reg, idle_sec_reg;
  logic [7:0]  aam_lvl_reg;
  logic [15:0] pio_time_reg, dma_time_reg;
  logic [47:0] limit_reg, w100_reg;
  logic [27:0] w60_reg;
  logic [PW-1:0] presc_reg;
  logic [2:0]  hr_sync_reg;
  logic        hr_level_reg;
  logic [31:0] rd_word;
  // Bus handshake: one wait cycle, write acts on the released edge
  wire req      = avs_read_in | avs_write_in;
  wire wr_do    = avs_write_in & ack_reg;
  wire rd_load  = avs_read_in & ~ack_reg;
  assign avs_waitrequest_out = req & ~ack_reg;
  // Address decode
  wire [31:0] wd   = avs_writedata_in;
  wire sel_task    = avs_address_in == `OFS_TASK;
  wire sel_task2   = avs_address_in == `OFS_TASK2;
  wire sel_cmd     = avs_address_in == `OFS_CMD;
  wire sel_ctrl    = avs_address_in == `OFS_CTRL;
  wire cmd_go      = wr_do & sel_cmd;
  wire [7:0] op    = wd[7:0];
  wire [7:0] feat  = tf_reg.feature;
  wire [7:0] lvl   = tf_reg.count;
  // Reset events: pin edge after filtering, soft reset by control write
  wire hr_stable   = hr_sync_reg[1] == hr_sync_reg[2];
  wire hard_evt    = hr_stable & ~hr_sync_reg[2] & hr_level_reg;
  wire soft_evt    = wr_do & sel_ctrl & wd[`CTRL_SRST];
  wire pwr_reinit  = hard_evt | (soft_evt & ~rev_dis_reg);
  // Set features decode
  wire is_sf       = cmd_go & (op == `OP_SETFEAT);
  wire lvl_bad     = (lvl == `LVL_ZERO) | (lvl == `LVL_ALL);
  wire lvl_norm    = lvl >= `LVL_NORM_MIN;
  wire lvl_lpi     = (lvl >= `LVL_LPI_MIN) & ~lvl_norm;
  wire lvl_long    = (lvl >= `LVL_LONG_MIN) & (lvl < `LVL_LPI_MIN);
  wire aam_bad     = (lvl == `LVL_ALL) | (lvl < `LVL_LPI_MIN);
  wire apm_ok      = is_sf & (feat == `FT_APM_EN) & ~lvl_bad;
  wire apm_off     = is_sf & (feat == `FT_APM_DIS);
  wire aam_ok      = is_sf & (feat == `FT_AAM_EN) & ~aam_bad;
  wire sf_known    = (feat == `FT_APM_EN) | (feat == `FT_APM_DIS) |
                     (feat == `FT_AAM_EN) | (feat == `FT_AAM_DIS) |
                     (feat == `FT_HOSTTIME) | (feat == `FT_REV_DIS) |
                     (feat == `FT_REV_EN);
  wire sf_abort    = ~sf_known | ((feat == `FT_APM_EN) & lvl_bad) |
                     ((feat == `FT_AAM_EN) & aam_bad);
  // Delay formulas, valid only inside their level ranges
  wire [8:0]  y1_calc = {1'b0, lvl - `LVL_LPI_MIN} * `Y1_STEP + `Y1_DEF;
  wire [12:0] y2_calc = {5'h00, lvl - `LVL_LONG_MIN} * `Y2_STEP
                        + `Y2_BASE;
  // Capacity-limit decode; 28-bit request from the task file
  wire is_sm       = cmd_go & (op == `OP_SETMAX);
  wire [47:0] req_lba = {20'h00000, tf_reg.dev_head[3:0], tf_reg.lba_high,
                         tf_reg.lba_mid, tf_reg.lba_low};
  wire sm_nv       = lvl[`SC_NV_BIT];
  wire sm_abort    = (sec_reg != apm_cap_pkg::SEC_OPEN) | hpa_ext_reg |
                     (sm_nv & (offset_reg | nv_done_reg)) |
                     (req_lba > NATIVE_MAX);
  wire big_clip    = (NATIVE_MAX > `LBA28_MAX) & (req_lba == `LBA28_MAX);
  wire [47:0] new_limit = big_clip ? NATIVE_MAX : req_lba;
  wire sec_range   = (feat >= `SM_SET_PW) & (feat <= `SM_FREEZE);
  wire sec_abort   = ~sec_range | (sec_reg == apm_cap_pkg::SEC_FROZEN) |
                     ((sec_reg == apm_cap_pkg::SEC_LOCKED) &
                      (feat != `SM_UNLOCK));
  wire sm_limit    = is_sm & native_rd_reg;
  wire sm_done     = sm_limit & ~sm_abort;
  wire sec_done    = is_sm & ~native_rd_reg & ~sec_abort;
  wire cmd_abort   = (is_sf & sf_abort) | (sm_limit & sm_abort) |
                     (is_sm & ~native_rd_reg & sec_abort);
  wire [47:0] native28 = (NATIVE_MAX > `LBA28_MAX) ? `LBA28_MAX : NATIVE_MAX;
  // Seconds timer, restarted by every host command
  wire sec_tick    = presc_reg == PW'(CYCLES_PER_SEC - 1);
  wire restart     = cmd_go | hard_evt | soft_evt;
  wire y1_due      = y1_set_reg & (idle_sec_reg >= {4'h0, y1_reg});
  wire y2_due      = idle_sec_reg >= y2_reg;
  // Power state walk
  always_comb begin
    pwr_next = pwr_reg;
    case (pwr_reg)
      apm_cap_pkg::PWR_ACTIVE: begin
        if (deep_reg != apm_cap_pkg::DEEP_NORMAL && y1_due) begin
          pwr_next = apm_cap_pkg::PWR_LPI;
        end
      end
      apm_cap_pkg::PWR_LPI: begin
        if (deep_reg == apm_cap_pkg::DEEP_SLOW && y2_due) begin
          pwr_next = apm_cap_pkg::PWR_SLOW;
        end
      end
      apm_cap_pkg::PWR_SLOW: pwr_next = apm_cap_pkg::PWR_SLOW;
      default: pwr_next = apm_cap_pkg::PWR_ACTIVE;
    endcase
    if (restart || deep_reg == apm_cap_pkg::DEEP_NORMAL) begin
      pwr_next = apm_cap_pkg::PWR_ACTIVE;
    end
  end
  // Read mux; unmapped offsets read as zero
  assign rd_word =
    sel_task  ? {tf_reg.lba_mid, tf_reg.lba_low, tf_reg.count,
                 tf_reg.feature} :
    sel_task2 ? {16'h0000, tf_reg.dev_head, tf_reg.lba_high} :
    sel_cmd   ? {16'h0000, 5'h00, abt_reg, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1,
                 3'h0, abt_reg} :
    sel_ctrl  ? {30'h00000000, offset_reg, 1'b0} :
    (avs_address_in == `OFS_POWER) ?
      {16'h0000, aam_lvl_reg, aam_en_reg, quiet_seek_out, y1_set_reg,
       pwr_reg, deep_reg} :
    (avs_address_in == `OFS_DELAY) ?
      {3'h0, y2_reg, 7'h00, y1_reg} :
    (avs_address_in == `OFS_HOSTTIME) ? {dma_time_reg, pio_time_reg} :
    (avs_address_in == `OFS_ID60) ? {4'h0, w60_reg} :
    (avs_address_in == `OFS_ID100L) ? w100_reg[31:0] :
    (avs_address_in == `OFS_ID100H) ?
      {12'h000, sec_reg == apm_cap_pkg::SEC_FROZEN,
       sec_reg == apm_cap_pkg::SEC_LOCKED, hpa_ext_reg, nv_done_reg,
       w100_reg[47:32]} : 32'h00000000;
  // Bus slave registers and reset pin synchroniser
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      ack_reg          <= 1'b0;
      avs_readdata_out <= 32'h00000000;
      hr_sync_reg      <= 3'b111;
      hr_level_reg     <= 1'b1;
    end else begin
      ack_reg          <= req & ~ack_reg;
      hr_sync_reg      <= {hr_sync_reg[1:0], hard_reset_n_in};
      avs_readdata_out <= rd_load ? rd_word : avs_readdata_out;
      hr_level_reg     <= hr_stable ? hr_sync_reg[2] : hr_level_reg;
    end
  end
  // Task file, command outcome and native-max flag
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      tf_reg        <= '0;
      abt_reg       <= 1'b0;
      native_rd_reg <= 1'b0;
      offset_reg    <= 1'b0;
    end else begin
      if (wr_do && sel_task) begin
        {tf_reg.lba_mid, tf_reg.lba_low, tf_reg.count, tf_reg.feature} <= wd;
      end
      if (wr_do && sel_task2) begin
        {tf_reg.dev_head, tf_reg.lba_high} <= wd[15:0];
      end
      if (wr_do && sel_ctrl) begin
        offset_reg <= wd[`CTRL_OFFSET];
      end
      if (cmd_go) begin
        abt_reg       <= cmd_abort;
        native_rd_reg <= op == `OP_RDNATIVE;
      end
      if (cmd_go && op == `OP_RDNATIVE) begin
        {tf_reg.dev_head[3:0], tf_reg.lba_high, tf_reg.lba_mid,
         tf_reg.lba_low} <= native28[27:0];
      end
    end
  end
  // Power-saving configuration
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || pwr_reinit) begin
      deep_reg   <= apm_cap_pkg::DEEP_NORMAL;
      y1_set_reg <= 1'b0;
      y1_reg     <= `Y1_DEF;
      y2_reg     <= `Y2_BASE;
    end else if (apm_off || (apm_ok && lvl_norm)) begin
      deep_reg   <= apm_cap_pkg::DEEP_NORMAL;
      y1_set_reg <= 1'b0;
    end else if (apm_ok && lvl_lpi) begin
      deep_reg   <= apm_cap_pkg::DEEP_LPI;
      y1_reg     <= y1_calc;
      y1_set_reg <= 1'b1;
    end else if (apm_ok) begin
      deep_reg   <= apm_cap_pkg::DEEP_SLOW;
      y1_set_reg <= 1'b1;
      if (!y1_set_reg) begin
        y1_reg <= `Y1_DEF;
      end
      y2_reg <= lvl_long ? y2_calc : `Y2_BASE;
    end
  end
  // Revert flag, acoustic mode and host-rate times; acoustic only at power-on
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      aam_en_reg   <= 1'b0;
      aam_lvl_reg  <= `LVL_NORM_MIN;
      rev_dis_reg  <= 1'b1;
      pio_time_reg <= 16'h0000;
      dma_time_reg <= 16'h0000;
    end else begin
      if (hard_evt) begin
        rev_dis_reg <= 1'b1;
      end else if (is_sf && feat == `FT_REV_DIS) begin
        rev_dis_reg <= 1'b1;
      end else if (is_sf && feat == `FT_REV_EN) begin
        rev_dis_reg <= 1'b0;
      end
      if (aam_ok) begin
        aam_en_reg  <= 1'b1;
        aam_lvl_reg <= lvl;
      end else if (is_sf && feat == `FT_AAM_DIS) begin
        aam_en_reg <= 1'b0;
      end
      if (is_sf && feat == `FT_HOSTTIME) begin
        pio_time_reg <= {tf_reg.lba_low, tf_reg.count};
        dma_time_reg <= {tf_reg.lba_high, tf_reg.lba_mid};
      end
    end
  end
  // Capacity limit, reported words and security state
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      limit_reg   <= NATIVE_MAX;
      w60_reg     <= native28[27:0];
      w100_reg    <= NATIVE_MAX;
      nv_done_reg <= 1'b0;
      hpa_ext_reg <= 1'b0;
      sec_reg     <= apm_cap_pkg::SEC_OPEN;
    end else begin
      if (hard_evt) begin
        nv_done_reg <= 1'b0;
      end else if (sm_done && sm_nv) begin
        nv_done_reg <= 1'b1;
      end
      if (sm_done) begin
        limit_reg <= new_limit;
        w60_reg   <= req_lba[27:0];
        w100_reg  <= new_limit;
      end
      if (cmd_go && op == `OP_SETMAXEXT) begin
        hpa_ext_reg <= 1'b1;
      end
      if (sec_done) begin
        case (feat)
          `SM_LOCK:   sec_reg <= apm_cap_pkg::SEC_LOCKED;
          `SM_FREEZE: sec_reg <= apm_cap_pkg::SEC_FROZEN;
          default:    sec_reg <= apm_cap_pkg::SEC_OPEN;
        endcase
      end
    end
  end
  // Timer, power state and drive-side outputs
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      presc_reg           <= '0;
      idle_sec_reg        <= 13'h0000;
      pwr_reg             <= apm_cap_pkg::PWR_ACTIVE;
      electronics_off_out <= 1'b0;
      heads_parked_out    <= 1'b0;
      spindle_pct_out     <= `SPD_FULL;
      quiet_seek_out      <= 1'b0;
      access_reject_out   <= 1'b0;
    end else begin
      presc_reg <= (restart || sec_tick) ? '0 : presc_reg + 1'b1;
      if (restart) begin
        idle_sec_reg <= 13'h0000;
      end else if (sec_tick && idle_sec_reg != 13'h1FFF) begin
        idle_sec_reg <= idle_sec_reg + 13'h0001;
      end
      pwr_reg             <= pwr_next;
      electronics_off_out <= pwr_next == apm_cap_pkg::PWR_LPI;
      heads_parked_out    <= pwr_next != apm_cap_pkg::PWR_ACTIVE;
      spindle_pct_out     <= (pwr_next == apm_cap_pkg::PWR_SLOW) ?
                             `SPD_SLOW : `SPD_FULL;
      quiet_seek_out      <= aam_en_reg & (aam_lvl_reg < `LVL_NORM_MIN);
      access_reject_out   <= access_valid_in &
                             (access_lba_in > limit_reg);
    end
  end
  // Checks on command outcomes and state
  property p_apm_abort;
    is_sf && feat == `FT_APM_EN && lvl_bad |=> abt_reg;
  endproperty
  a_apm_abort: assert property (p_apm_abort)
    else $error("bad power level not aborted");
  property p_lpi_delay;
    apm_ok && lvl_lpi && !pwr_reinit |=>
      deep_reg == apm_cap_pkg::DEEP_LPI &&
      y1_reg == {1'b0, $past(lvl) - 8'h80} * 9'h005 + 9'h078;
  endproperty
  a_lpi_delay: assert property (p_lpi_delay)
    else $error("low idle delay wrong");
  property p_long_delay;
    apm_ok && lvl_long && !pwr_reinit |=>
      y2_reg == {5'h00, $past(lvl) - 8'h40} * 13'h003C + 13'h0258;
  endproperty
  a_long_delay: assert property (p_long_delay)
    else $error("standby delay wrong");
  property p_short_delay;
    apm_ok && lvl < 8'h40 && !pwr_reinit |=> y2_reg == 13'h0258;
  endproperty
  a_short_delay: assert property (p_short_delay)
    else $error("fixed standby delay not 600");
  property p_y1_default;
    apm_ok && lvl < 8'h80 && !y1_set_reg && !pwr_reinit |=>
      y1_reg == 9'h078 && y1_set_reg;
  endproperty
  a_y1_default: assert property (p_y1_default)
    else $error("default low idle delay missing");
  property p_apm_off;
    apm_off |=> deep_reg == apm_cap_pkg::DEEP_NORMAL ##1
      pwr_reg == apm_cap_pkg::PWR_ACTIVE;
  endproperty
  a_apm_off: assert property (p_apm_off)
    else $error("disable left a saving state");
  property p_aam_abort;
    is_sf && feat == `FT_AAM_EN && aam_bad |=>
      abt_reg && $stable(aam_lvl_reg);
  endproperty
  a_aam_abort: assert property (p_aam_abort)
    else $error("bad acoustic level accepted");
  property p_sec_lock;
    is_sm && !native_rd_reg && feat == 8'h02 &&
      sec_reg == apm_cap_pkg::SEC_OPEN |=>
      sec_reg == apm_cap_pkg::SEC_LOCKED && !abt_reg;
  endproperty
  a_sec_lock: assert property (p_sec_lock)
    else $error("security lock not decoded");
  property p_locked_abort;
    sm_limit && sec_reg != apm_cap_pkg::SEC_OPEN |=>
      abt_reg && $stable(limit_reg);
  endproperty
  a_locked_abort: assert property (p_locked_abort)
    else $error("limit set while locked");
  property p_reject;
    access_valid_in && access_lba_in > limit_reg |=> access_reject_out;
  endproperty
  a_reject: assert property (p_reject)
    else $error("access beyond limit passed");
  property p_slow_speed;
    pwr_reg == apm_cap_pkg::PWR_SLOW |->
      heads_parked_out && spindle_pct_out == 7'h3E;
  endproperty
  a_slow_speed: assert property (p_slow_speed)
    else $error("slow standby outputs wrong");
endmodule : apm_cap_cmd

// [apm_cap_map.svh]
// Offsets, field positions, codes and timing counts of the command block
`ifndef APM_CAP_MAP_SVH
`define APM_CAP_MAP_SVH
// Register byte offsets on the Avalon slave
`define OFS_TASK     8'h00
`define OFS_TASK2    8'h04
`define OFS_CMD      8'h08
`define OFS_CTRL     8'h0C
`define OFS_POWER    8'h10
`define OFS_DELAY    8'h14
`define OFS_HOSTTIME 8'h18
`define OFS_ID60     8'h1C
`define OFS_ID100L   8'h20
`define OFS_ID100H   8'h24
// Control register bits
`define CTRL_SRST    0
`define CTRL_OFFSET  1
// Opcodes
`define OP_SETFEAT   8'hEF
`define OP_SETMAX    8'hF9
`define OP_RDNATIVE  8'hF8
`define OP_SETMAXEXT 8'h37
// Feature codes
`define FT_APM_EN    8'h05
`define FT_APM_DIS   8'h85
`define FT_AAM_EN    8'h42
`define FT_AAM_DIS   8'hC2
`define FT_HOSTTIME  8'h43
`define FT_REV_DIS   8'h66
`define FT_REV_EN    8'hCC
// Security subcommands
`define SM_SET_PW    8'h01
`define SM_LOCK      8'h02
`define SM_UNLOCK    8'h03
`define SM_FREEZE    8'h04
// Level thresholds
`define LVL_ZERO     8'h00
`define LVL_ALL      8'hFF
`define LVL_NORM_MIN 8'hC0
`define LVL_LPI_MIN  8'h80
`define LVL_LONG_MIN 8'h40
// Delay formulas, in seconds
`define Y1_DEF       9'h078
`define Y1_STEP      9'h005
`define Y2_BASE      13'h0258
`define Y2_STEP      13'h003C
// Capacity
`define LBA28_MAX    48'h0000_0FFF_FFFF
`define SC_NV_BIT    0
// Status and error bits
`define ST_RDY       6
`define ST_DSC       4
`define ST_ERR       0
`define ER_ABT       2
// Spindle speed in percent
`define SPD_FULL     7'h64
`define SPD_SLOW     7'h3E
// Timing: one second and the clock period, in ns
`define SEC_NS       1000000000
`define CLK_NS       40
`endif

// [apm_cap_pkg.sv]
// Types shared by the power, acoustic and capacity command block
package apm_cap_pkg;
  typedef enum logic [2:0] {
    PWR_ACTIVE = 3'b001,
    PWR_LPI    = 3'b010,
    PWR_SLOW   = 3'b100
  } pwr_state_e;

  typedef enum logic [1:0] {
    DEEP_NORMAL = 2'b00,
    DEEP_LPI    = 2'b01,
    DEEP_SLOW   = 2'b10
  } deepest_e;

  typedef enum logic [2:0] {
    SEC_OPEN   = 3'b001,
    SEC_LOCKED = 3'b010,
    SEC_FROZEN = 3'b100
  } sec_state_e;

  typedef struct packed {
    logic [7:0] dev_head;
    logic [7:0] lba_high;
    logic [7:0] lba_mid;
    logic [7:0] lba_low;
    logic [7:0] count;
    logic [7:0] feature;
  } taskfile_s;
endpackage : apm_cap_pkg

// [host_adapter.sv]
// Host adapter model: Avalon-MM master for task-file traffic
`timescale 1ns/1ps
module host_adapter (
  input  wire logic        clk_in,
  input  wire logic        waitreq_in,
  input  wire logic [31:0] rdata_in,
  output logic      [7:0]  addr_out,
  output logic             rd_out,
  output logic             wr_out,
  output logic      [31:0] wdata_out
);
  // Idle bus from time zero
  initial begin
    addr_out  = 8'h00;
    rd_out    = 1'h0;
    wr_out    = 1'h0;
    wdata_out = 32'h0;
  end

  // One word; held until waitrequest is sampled low at a rising edge.
  // A hung slave is left to the bench watchdog, never cut short here.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= w;
    rd_out    <= ~w;
    do begin
      @(posedge clk_in);
    end while (waitreq_in !== 1'h0);
    q = rdata_in;
    rd_out    <= 1'h0;
    wr_out    <= 1'h0;
    wdata_out <= ~d; // Released data is not left looking valid
  endtask : xfer
endmodule : host_adapter

// [power_acoustic_capacity_cmds_tb.sv]
// Self-checking bench for the power, acoustic and capacity commands
`timescale 1ns/1ps
`include "apm_cap_map.svh"
module power_acoustic_capacity_cmds_tb;
  localparam int          CPS  = 4;
  localparam logic [47:0] NMAX = 48'h0000_1D1C_5970;
  logic        clk, rst_n, hard_n, rd, wr, wreq, acc_v, rej;
  logic        eoff, park, quiet;
  logic [6:0]  spd;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic [47:0] acc_lba;
  int          error_cnt, compares;

  apm_cap_cmd #(.CYCLES_PER_SEC(CPS), .NATIVE_MAX(NMAX)) dut_u (
    .ref_clk_in(clk), .rst_n_in(rst_n), .hard_reset_n_in(hard_n),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .access_valid_in(acc_v),
    .access_lba_in(acc_lba), .access_reject_out(rej),
    .electronics_off_out(eoff), .heads_parked_out(park),
    .spindle_pct_out(spd), .quiet_seek_out(quiet));
  host_adapter host_u (.clk_in(clk), .waitreq_in(wreq), .rdata_in(rdata),
    .addr_out(addr), .rd_out(rd), .wr_out(wr), .wdata_out(wdata));

  // 25 MHz clock
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // Expected idle delays in seconds
  function automatic logic [31:0] y1f(input logic [7:0] x);
    return (32'(x) - 32'h80) * 32'h5 + 32'h78;
  endfunction : y1f
  function automatic logic [31:0] y2f(input logic [7:0] x);
    return (x >= 8'h40) ? (32'(x) - 32'h40) * 32'h3C + 32'h258 : 32'h258;
  endfunction : y2f

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic rg(input logic [7:0] a, output logic [31:0] q);
    host_u.xfer(1'h0, a, 32'h0, q);
  endtask : rg
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host_u.xfer(1'h1, a, d, q);
  endtask : wreg
  // Task file, opcode, then status; ab of x skips the abort check
  task automatic run(input logic [7:0] op, input logic [7:0] ft,
                     input logic [7:0] cn, input logic [27:0] a,
                     input logic ab);
    logic [31:0] st;
    wreg(`OFS_TASK, {a[15:0], cn, ft});
    wreg(`OFS_TASK2, {16'h0, 4'hE, a[27:16]});
    wreg(`OFS_CMD, {24'h0, op});
    rg(`OFS_CMD, st);
    if (ab !== 1'hx) chk({30'h0, st[10], st[0]}, {30'h0, ab, ab});
  endtask : run
  task automatic setmax(input logic [7:0] cn, input logic [27:0] a,
                        input logic ab);
    run(`OP_RDNATIVE, 8'h00, 8'h00, 28'h0, 1'h0);
    run(`OP_SETMAX, 8'h00, cn, a, ab);
  endtask : setmax
  // Media probe; reject is registered, seen the cycle after
  task automatic probe(input logic [47:0] a, input logic e);
    @(posedge clk);
    acc_v   <= 1'h1;
    acc_lba <= a;
    @(posedge clk);
    acc_v   <= 1'h0;
    acc_lba <= ~a;
    @(negedge clk);
    chk(32'(rej), 32'(e));
  endtask : probe
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  // Main sequence
  initial begin
    logic [31:0] q, t;
    logic [7:0]  x;
    logic [27:0] lim;
    logic [15:0] aam [5];
    aam = '{16'h8001, 16'hC000, 16'h7F02, 16'hFF02, 16'hBF01};
    error_cnt = 0;
    compares = 0;
    rst_n = 1'h0;
    hard_n = 1'h1;
    acc_v = 1'h0;
    acc_lba = 48'h0;
    void'($urandom(32'hF507BF63));
    repeat (5) @(posedge clk);
    chk({25'h0, spd}, {25'h0, `SPD_FULL});
    rst_n <= 1'h1;
    // Slow standby level before any idle delay exists
    x = 8'(32'h1 + $urandom % 32'h3F);
    run(`OP_SETFEAT, `FT_APM_EN, x, 28'h0, 1'h0);
    rg(`OFS_DELAY, q);
    chk(32'(q[8:0]), 32'h78);
    chk(32'(q[28:16]), y2f(x));
    rg(`OFS_POWER, q);
    chk(32'(q[1:0]), 32'h2);
    repeat (y2f(x) * CPS + 20) @(posedge clk);
    chk({30'h0, park, spd == `SPD_SLOW}, 32'h3);
    // Low power idle; waits past 600 s to show no slow spin
    x = 8'(32'h80 + $urandom % 32'h40);
    t = y1f(x);
    run(`OP_SETFEAT, `FT_APM_EN, x, 28'h0, 1'h0);
    rg(`OFS_DELAY, q);
    chk(32'(q[8:0]), t);
    repeat (2420) @(posedge clk);
    chk({23'h0, eoff, park, spd}, {23'h0, 2'h3, `SPD_FULL});
    x = 8'(32'h40 + $urandom % 32'h40);
    run(`OP_SETFEAT, `FT_APM_EN, x, 28'h0, 1'h0);
    rg(`OFS_DELAY, q);
    chk(32'(q[8:0]), t);
    chk(32'(q[28:16]), y2f(x));
    run(`OP_SETFEAT, `FT_APM_DIS, 8'h00, 28'h0, 1'h0);
    rg(`OFS_POWER, q);
    chk(32'(q[1:0]), 32'h0);
    x = 8'(32'hC0 + $urandom % 32'h3F);
    run(`OP_SETFEAT, `FT_APM_EN, x, 28'h0, 1'h0);
    rg(`OFS_POWER, q);
    chk(32'(q[1:0]), 32'h0);
    run(`OP_SETFEAT, `FT_APM_EN, 8'h00, 28'h0, 1'h1);
    run(`OP_SETFEAT, `FT_APM_EN, 8'hFF, 28'h0, 1'h1);
    // Soft reset honours the revert setting
    run(`OP_SETFEAT, `FT_REV_DIS, 8'h00, 28'h0, 1'h0);
    run(`OP_SETFEAT, `FT_APM_EN, 8'h90, 28'h0, 1'h0);
    wreg(`OFS_CTRL, 32'h1);
    rg(`OFS_POWER, q);
    chk(32'(q[1:0]), 32'h1);
    run(`OP_SETFEAT, `FT_REV_EN, 8'h00, 28'h0, 1'h0);
    wreg(`OFS_CTRL, 32'h1);
    rg(`OFS_POWER, q);
    chk(32'(q[1:0]), 32'h0);
    foreach (aam[i]) begin
      run(`OP_SETFEAT, `FT_AAM_EN, aam[i][15:8], 28'h0, aam[i][1]);
      chk(32'(quiet), 32'(aam[i][0]));
    end
    // Hard reset clears power mode but not acoustic mode
    run(`OP_SETFEAT, `FT_APM_EN, 8'h90, 28'h0, 1'h0);
    hard_n <= 1'h0;
    repeat (6) @(posedge clk);
    hard_n <= 1'h1;
    repeat (10) @(posedge clk);
    chk(32'(quiet), 32'h1);
    run(`OP_SETFEAT, `FT_AAM_DIS, 8'h00, 28'h0, 1'h0);
    chk(32'(quiet), 32'h0);
    rg(`OFS_POWER, q);
    chk(32'(q[1:0]), 32'h0);
    t = $urandom;
    run(`OP_SETFEAT, `FT_HOSTTIME, t[7:0], {4'h0, t[31:8]}, 1'h0);
    rg(`OFS_HOSTTIME, q);
    chk(q, t);
    // Capacity limit, its reporting and enforcement
    lim = 28'(32'h100 + $urandom % 32'h0FFFFE00);
    setmax(8'h00, lim, 1'h0);
    rg(`OFS_ID60, q);
    chk(q, {4'h0, lim});
    rg(`OFS_ID100L, q);
    chk(q, {4'h0, lim});
    probe({20'h0, lim}, 1'h0);
    probe({20'h0, lim} + 48'h1, 1'h1);
    run(`OP_RDNATIVE, 8'h00, 8'h00, 28'h0, 1'h0);
    run(`OP_SETFEAT, `FT_APM_DIS, 8'h00, 28'h0, 1'h0);
    run(`OP_SETMAX, `SM_SET_PW, 8'h00, 28'h50, 1'h0);
    rg(`OFS_ID60, q);
    chk(q, {4'h0, lim});
    setmax(8'h00, 28'hFFF_FFFF, 1'h0);
    rg(`OFS_ID60, q);
    chk(q, 32'h0FFF_FFFF);
    rg(`OFS_ID100L, q);
    chk(q, NMAX[31:0]);
    rg(`OFS_ID100H, q);
    chk(32'(q[15:0]), 32'(NMAX[47:32]));
    wreg(`OFS_CTRL, 32'h2);
    setmax(8'h01, lim, 1'h1);
    wreg(`OFS_CTRL, 32'h0);
    setmax(8'h01, lim, 1'h0);
    setmax(8'h01, lim, 1'h1);
    run(`OP_SETMAX, `SM_LOCK, 8'h00, 28'h0, 1'h0);
    setmax(8'h00, lim, 1'h1);
    run(`OP_SETMAX, `SM_UNLOCK, 8'h00, 28'h0, 1'h0);
    setmax(8'h00, lim, 1'h0);
    run(`OP_SETMAX, `SM_FREEZE, 8'h00, 28'h0, 1'h0);
    setmax(8'h00, lim, 1'h1);
    rst_n <= 1'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    run(`OP_SETMAXEXT, 8'h00, 8'h00, 28'h0, 1'h0);
    setmax(8'h00, lim, 1'h1);
    results();
  end

  // Watchdog, about 50000 cycles
  initial begin
    #2000000;
    error_cnt++;
    results();
  end
endmodule : power_acoustic_capacity_cmds_tb
